// ==== include/srbs_pkg.sv ====
`default_nettype none
package srbs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] SRBS_ADDR_SELF = 5'h13;
  localparam logic [4:0] SRBS_ADDR_NO_OPERATION = 5'h00;
  localparam logic [4:0] SRBS_ADDR_STATUS = 5'h16;
  localparam logic [4:0] SRBS_ADDR_ID3 = 5'h1c;
  localparam logic [21:0] SRBS_RESET_VALUE = 22'h130000;
  localparam int SRBS_REG_WIDTH = 22;
  localparam int SRBS_FAULT_BIT = 21;
  localparam int SRBS_ADDR_LSB = 16;
  localparam int SRBS_MODE_LSB = 5;
  localparam int SRBS_TARGET_LSB = 0;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int SRBS_FRAME_BITS = 24;
  localparam int SRBS_CNT_W = 5;
  localparam logic [4:0] SRBS_FRAME_LAST = 5'h17;
  localparam int SRBS_RW_BIT = 23;
  localparam int SRBS_DEVADR_LSB = 21;
  localparam int SRBS_REGADR_LSB = 16;

  // Readback modes.
  typedef enum logic [1:0] {
    SRBS_MODE_TWO_STAGE = 2'h0,
    SRBS_MODE_AUTOSTATUS = 2'h1,
    SRBS_MODE_SHARED = 2'h2,
    SRBS_MODE_ALTERNATE = 2'h3
  } srbs_mode_e;

  // Decoded incoming frame.
  typedef struct packed {
    logic is_read;
    logic [1:0] dev_addr;
    logic [4:0] reg_addr;
    logic [15:0] data;
  } srbs_frame_s;

  // Configuration held in the register.
  typedef struct packed {
    srbs_mode_e mode;
    logic [4:0] target;
  } srbs_cfg_s;

  // True for target codes that name a real register.
  function automatic logic srbs_target_ok(input logic [4:0] code);
    srbs_target_ok = (code <= 5'h0a) || ((code >= 5'h0f) && (code <= 5'h18)) || (code == SRBS_ADDR_ID3);
  endfunction

endpackage
`default_nettype wire

// ==== hw/srbs_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module srbs_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out.
  input wire logic d,
  output logic q
);

  logic meta_q;
  logic meta_d;
  logic q_d;

  // Only the second stage reads the first.
  always_comb
  begin
    meta_d = d;
    q_d = meta_q;
  end

  // Two-stage synchroniser register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule
`default_nettype wire

// ==== hw/srbs_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
module srbs_shifter
(
  // Link clock and frame reset.
  input wire logic sclk,
  input wire logic frame_n,
  // Serial data.
  input wire logic sdi,
  output logic sdo,
  // Word to send, loaded at frame start.
  input wire logic [23:0] tx_word,
  // Received word and done pulse.
  output srbs_pkg::srbs_frame_s rx_word,
  output logic rx_done
);

  logic [22:0] sh_q;
  logic [22:0] sh_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic done_q;
  logic done_d;

  // The frame-select line acts as the reset so nothing waits on a link edge after the frame ends.
  always_comb
  begin
    sh_d = {sh_q[21:0], sdi};
    cnt_d = (cnt_q == srbs_pkg::SRBS_FRAME_LAST) ? cnt_q : cnt_q + 5'h01;
    done_d = done_q || (cnt_q == srbs_pkg::SRBS_FRAME_LAST);
  end

  // Data shifts in on the rising link edge.
  always_ff @(posedge sclk or posedge frame_n)
  begin
    if (frame_n)
    begin
      sh_q <= 23'h000000;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end
    else
    begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  // Output bit chosen by the bit counter; the word is stable through the frame.
  always_comb
  begin
    sdo = tx_word[srbs_pkg::SRBS_FRAME_LAST - cnt_q];
  end

  // Word and strobe describe the pending 24th edge, since the link clock stops after it.
  // A registered strobe would never be seen; further edges in the same frame are ignored.
  assign rx_word = {sh_q, sdi};
  assign rx_done = (cnt_q == srbs_pkg::SRBS_FRAME_LAST) && !done_q;

endmodule
`default_nettype wire

// ==== hw/srbs_top.sv ====
// How it works
// - Register sits at 0x13 and resets to 0x130000, its address in bits 20:16.
// - Bit 21 is read-only and mirrors the current fault pin level.
// - Bits 4:0 hold the two-stage target address, read/write, reset zero.
// - Bits 6:5 choose return mode; zero after reset means two-stage read.
// - Mode 01 sends the status word on SDO in every frame.
// - Mode 11 alternates status and the previous frame's instruction on each frame addressed to this device.
// - Mode 10 flags each valid write, then sends status when the flag is set.
// - Devices sharing frame select are told apart by hardware address pins.
// - Target codes 0x00-0x0a, 0x0f-0x18 and 0x1c select registers; 0x00 is reset.
`timescale 1ns/100ps
`default_nettype none
module srbs_top
(
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial link.
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  // Hardware address pins.
  input wire logic [1:0] hw_addr,
  // Fault pin level as driven by the device.
  input wire logic fault_pin,
  // Register file read port: contents of the register being read back.
  output logic [4:0] rd_addr,
  input wire logic [15:0] rd_data,
  // Status register contents.
  input wire logic [15:0] status_word,
  // Configuration seen by the rest of the device.
  output srbs_pkg::srbs_cfg_s cfg
);

  // -----------------------------------------------------------------
  // Reset and input synchronisers
  // -----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_meta_d;
  logic rst_n_q;
  logic rst_n_d;

  // Release climbs one stage per clock; only the second stage is used by the logic.
  always_comb
  begin
    rst_meta_d = 1'b1;
    rst_n_d = rst_meta_q;
  end

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= rst_meta_d;
      rst_n_q <= rst_n_d;
    end
  end

  logic fault_s;
  logic done_tgl_s;

  // The fault level is asynchronous to every clock here, so it is synchronised before use.
  srbs_sync u_sync_fault
  (
    .clk(clk_sys),
    .rst_n(rst_n_q),
    .d(fault_pin),
    .q(fault_s)
  );

  // -----------------------------------------------------------------
  // Link side
  // -----------------------------------------------------------------
  // Word as the shifter sees it at the last link edge of a frame.
  srbs_pkg::srbs_frame_s rx_word;
  logic rx_done;
  logic [23:0] tx_word;

  srbs_shifter u_shift
  (
    .sclk(sclk),
    .frame_n(sync_n),
    .sdi(sdi),
    .sdo(sdo),
    .tx_word(tx_word),
    .rx_word(rx_word),
    .rx_done(rx_done)
  );

  // Frame capture on the link clock; a toggle carries the event across.
  logic done_tgl_q;
  logic done_tgl_d;
  srbs_pkg::srbs_frame_s cap_q;
  srbs_pkg::srbs_frame_s cap_d;

  always_comb
  begin
    done_tgl_d = rx_done ? ~done_tgl_q : done_tgl_q;
    cap_d = rx_done ? rx_word : cap_q;
  end

  // Kept on the link clock and left stable until the next frame completes.
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_tgl_q <= 1'b0;
      cap_q <= '0;
    end
    else
    begin
      done_tgl_q <= done_tgl_d;
      cap_q <= cap_d;
    end
  end

  // Only the toggle needs a synchroniser; the captured word is held until the next frame ends.
  srbs_sync u_sync_done
  (
    .clk(clk_sys),
    .rst_n(rst_n_q),
    .d(done_tgl_q),
    .q(done_tgl_s)
  );

  // -----------------------------------------------------------------
  // System side: frame decode and register
  // -----------------------------------------------------------------
  logic seen_tgl_q;
  logic frame_evt;
  srbs_pkg::srbs_frame_s frm_q;
  srbs_pkg::srbs_frame_s frm_d;

  // The captured word is stable for several system clocks before the toggle lands.
  always_comb
  begin
    frame_evt = done_tgl_s ^ seen_tgl_q;
    frm_d = frame_evt ? cap_q : frm_q;
  end

  logic for_me;
  logic wr_self;
  logic valid_write;

  // Address pins separate devices that share one frame select.
  always_comb
  begin
    for_me = (frm_d.dev_addr == hw_addr);
    valid_write = frame_evt && for_me && !frm_d.is_read;
    wr_self = valid_write && (frm_d.reg_addr == srbs_pkg::SRBS_ADDR_SELF);
  end

  // Configuration and the per-frame state of the return modes.
  srbs_pkg::srbs_cfg_s cfg_q;
  srbs_pkg::srbs_cfg_s cfg_d;
  logic wr_flag_q;
  logic wr_flag_d;
  logic alt_q;
  logic alt_d;
  logic [15:0] prev_instr_q;
  logic [15:0] prev_instr_d;

  // Register update and per-frame mode state.
  always_comb
  begin
    cfg_d = cfg_q;
    wr_flag_d = wr_flag_q;
    alt_d = alt_q;
    prev_instr_d = prev_instr_q;
    if (wr_self)
    begin
      cfg_d.mode = srbs_pkg::srbs_mode_e'(frm_d.data[6:5]);
      cfg_d.target = frm_d.data[4:0];
    end
    if (frame_evt && for_me)
    begin
      wr_flag_d = valid_write;
      alt_d = ~alt_q;
      prev_instr_d = {frm_d.is_read, frm_d.dev_addr, frm_d.reg_addr, 8'h00};
    end
  end

  // System-side state, registered only; seen_tgl_q copies done_tgl_s here, every other update is decided in the processes above.
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cfg_q <= '{mode: srbs_pkg::SRBS_MODE_TWO_STAGE, target: srbs_pkg::SRBS_ADDR_NO_OPERATION};
      wr_flag_q <= 1'b0;
      alt_q <= 1'b0;
      prev_instr_q <= 16'h0000;
      seen_tgl_q <= 1'b0;
      frm_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      wr_flag_q <= wr_flag_d;
      alt_q <= alt_d;
      prev_instr_q <= prev_instr_d;
      seen_tgl_q <= done_tgl_s;
      frm_q <= frm_d;
    end
  end

  // The rest of the device reads the register straight from its flops.
  assign cfg = cfg_q;

  // -----------------------------------------------------------------
  // Readback value of this register
  // -----------------------------------------------------------------
  logic [21:0] self_val;

  // Reserved bits 15:7 are held at zero; write data there is dropped.
  always_comb
  begin
    self_val = srbs_pkg::SRBS_RESET_VALUE;
    self_val[srbs_pkg::SRBS_FAULT_BIT] = fault_s;
    self_val[6:5] = cfg_q.mode;
    self_val[4:0] = cfg_q.target;
  end

  // -----------------------------------------------------------------
  // Return word selection
  // -----------------------------------------------------------------
  logic [23:0] tx_build;
  logic [23:0] tx_d;
  logic [23:0] tx_q;
  logic [15:0] sel_data;

  // The status word is framed the same way in every mode that returns it.
  function automatic logic [23:0] status_frame(input logic [15:0] contents);
    status_frame = {3'h0, srbs_pkg::SRBS_ADDR_STATUS, contents};
  endfunction

  // Register fetch; an unlisted code returns zero rather than stale data.
  always_comb
  begin
    rd_addr = cfg_q.target;
    if (!srbs_pkg::srbs_target_ok(cfg_q.target))
      sel_data = 16'h0000;
    else
      sel_data = rd_data;
  end

  // Word for the next frame, built on the system clock.
  always_comb
  begin
    case (cfg_q.mode)
      srbs_pkg::SRBS_MODE_AUTOSTATUS:
        tx_build = status_frame(status_word);
      srbs_pkg::SRBS_MODE_SHARED:
        tx_build = wr_flag_q ? status_frame(status_word) : 24'h000000;
      srbs_pkg::SRBS_MODE_ALTERNATE:
        tx_build = alt_q ? {8'h00, prev_instr_q} : status_frame(status_word);
      default:
      begin
        // The own register returns all 22 bits, so the fault mirror and its address field show.
        if (cfg_q.target == srbs_pkg::SRBS_ADDR_SELF)
          tx_build = {2'h0, self_val};
        else
          tx_build = {3'h0, cfg_q.target, sel_data};
      end
    endcase
  end

  // The word is frozen while frame select is low so the link sees a steady value.
  logic sync_s;

  srbs_sync u_sync_frame
  (
    .clk(clk_sys),
    .rst_n(rst_n_q),
    .d(sync_n),
    .q(sync_s)
  );

  // Loading goes on for two system clocks after select falls, so the word's inputs must settle first.
  always_comb
  begin
    tx_d = sync_s ? tx_build : tx_q;
  end

  // Return word register.
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
      tx_q <= 24'h000000;
    else
      tx_q <= tx_d;
  end

  assign tx_word = tx_q;

endmodule
`default_nettype wire

// ==== verif/srbs_top_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module srbs_props
(
  // Clocks and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  // Link pins.
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic sdo,
  // Device side.
  input wire logic [1:0] hw_addr,
  input wire logic [4:0] rd_addr,
  input wire logic [15:0] status_word,
  input wire srbs_pkg::srbs_cfg_s cfg
);
  // ------------
  // Frame shadow
  // ------------
  logic [4:0] cnt_q, cnt_d;
  logic [22:0] so_q, so_d, si_q, si_d;
  logic hit_q, hit_d;
  logic [3:0] idle_q, idle_d;
  logic [23:0] word;

  // Count bits and copy both lines; hit marks a whole write to this register.
  always_comb
  begin
    cnt_d = cnt_q + 5'h01;
    so_d = {so_q[21:0], sdo};
    si_d = {si_q[21:0], sdi};
    hit_d = (cnt_q == 5'h17) ? (si_q[22:15] == {1'h0, hw_addr, 5'h13}) : hit_q;
    idle_d = (!sync_n) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
  end

  // A raised select clears the count, so a cut frame never looks complete.
  always_ff @(posedge sclk or posedge sync_n)
  begin
    if (sync_n)
    begin
      cnt_q <= 5'h00;
      so_q <= 23'h000000;
      si_q <= 23'h000000;
    end
    else
    begin
      cnt_q <= cnt_d;
      so_q <= so_d;
      si_q <= si_d;
    end
  end

  // Write marker and idle time.
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
      hit_q <= 1'b0;
    else
      hit_q <= hit_d;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      idle_q <= 4'h0;
    else
      idle_q <= idle_d;
  end

  assign word = {so_q, sdo};

  property p_mirror;
    @(posedge clk_sys) disable iff (!nrst) rd_addr == cfg.target;
  endproperty
  a_mirror: assert property (p_mirror) else $error("rd_addr not target");

  property p_reset;
    @(posedge clk_sys) disable iff (!nrst) $rose(nrst) |-> (cfg == 7'h00) ##1 (cfg == 7'h00);
  endproperty
  a_reset: assert property (p_reset) else $error("cfg not zero after reset");

  property p_late;
    @(posedge clk_sys) disable iff (!nrst) $changed(cfg) |-> idle_q < 4'h9;
  endproperty
  a_late: assert property (p_late) else $error("cfg changed long after frame");

  property p_cause;
    @(posedge clk_sys) disable iff (!nrst) $changed(cfg) |-> hit_q;
  endproperty
  a_cause: assert property (p_cause) else $error("cfg changed without own write");

  property p_quiet;
    @(posedge clk_sys) disable iff (!nrst) !sync_n [*8] |-> $stable(cfg);
  endproperty
  a_quiet: assert property (p_quiet) else $error("cfg moved inside frame");

  property p_status;
    @(posedge sclk) disable iff (!nrst) cnt_q == 5'h17 && cfg.mode == srbs_pkg::SRBS_MODE_AUTOSTATUS
      |-> word == {3'h0, srbs_pkg::SRBS_ADDR_STATUS, status_word};
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");

  property p_two;
    @(posedge sclk) disable iff (!nrst) cnt_q == 5'h17 && cfg.mode == srbs_pkg::SRBS_MODE_TWO_STAGE
      |-> word[23:22] == 2'h0 && word[20:16] == cfg.target && (!word[21] || cfg.target == 5'h13);
  endproperty
  a_two: assert property (p_two) else $error("readback address wrong");

  property p_own;
    @(posedge sclk) disable iff (!nrst) cnt_q == 5'h17 && cfg == 7'h13 |-> word[15:0] == 16'h0013;
  endproperty
  a_own: assert property (p_own) else $error("own readback wrong");

  c_auto: cover property (@(posedge sclk) cnt_q == 5'h17 && cfg.mode == srbs_pkg::SRBS_MODE_AUTOSTATUS);
  c_shared: cover property (@(posedge clk_sys) cfg.mode == srbs_pkg::SRBS_MODE_SHARED);
  c_alt: cover property (@(posedge clk_sys) cfg.mode == srbs_pkg::SRBS_MODE_ALTERNATE);
endmodule

bind srbs_top srbs_props i_props (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
  .sdo(sdo), .hw_addr(hw_addr), .rd_addr(rd_addr), .status_word(status_word), .cfg(cfg));
`default_nettype wire

// ==== verif/srbs_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module srbs_host
(
  // Link pins toward the device.
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  // Return line.
  input wire logic sdo
);
  // ------------
  // Frame engine
  // ------------
  // Clock rests low between frames; data shows the inverse of its last bit.
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // One 24-bit frame, MSB first, 125 ns period; the dev field picks the device.
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = tx[i];
      #62.5;
      rx = {rx[22:0], sdo};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    sync_n = 1'b1;
    sdi = ~sdi;
    #1000;
  endtask
endmodule
`default_nettype wire

// ==== verif/srbs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sclk, sync_n, sdi, sdo;
  logic [1:0] hw_addr = 2'h2;
  logic fault_pin = 1'b0;
  logic [4:0] rd_addr;
  logic [15:0] rd_data;
  logic [15:0] status_word = 16'h8421;
  srbs_pkg::srbs_cfg_s cfg;
  int mismatches = 0;
  int samples_checked = 0;
  logic [23:0] st, w1, w2;
  logic [4:0] prev = 5'h00;
  logic [4:0] codes [5] = '{5'h1c, 5'h18, 5'h0f, 5'h0a, 5'h13};

  // -------
  // Harness
  // -------
  // Contents carry their own code, so a wrong selection shows.
  assign rd_data = {rd_addr, 11'h2a5};
  assign st = {3'h0, srbs_pkg::SRBS_ADDR_STATUS, status_word};
  always #25 clk_sys = ~clk_sys;

  srbs_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
    .hw_addr(hw_addr), .fault_pin(fault_pin), .rd_addr(rd_addr), .rd_data(rd_data),
    .status_word(status_word), .cfg(cfg));
  srbs_host i_host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Own register returns its address field and settings; others return their stand-in contents.
  function automatic logic [23:0] rb(input logic [4:0] c);
    rb = (c == 5'h13) ? 24'h130013 : {3'h0, c, c, 11'h2a5};
  endfunction

  task automatic f(input logic [23:0] tx, input logic [23:0] ex);
    logic [23:0] rx;
    @(posedge clk_sys);
    #1;
    i_host.xfer(tx, rx);
    check("sdo word", rx, ex);
  endtask

  // Each frame returns what the previous one selected.
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    check("cfg", {17'h00000, cfg}, 24'h000000);
    foreach (codes[i])
    begin
      f({8'h53, 11'h000, codes[i]}, rb(prev));
      prev = codes[i];
    end
    f(24'h53ff93, rb(5'h13));
    @(posedge clk_sys);
    #1 fault_pin = 1'b1;
    repeat (4) @(posedge clk_sys);
    f(24'h330021, 24'h330013);
    @(posedge clk_sys);
    #1 fault_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    f(24'h530020, rb(5'h13));
    f(24'hc00000, st);
    f(24'h530040, st);
    f(24'h330000, st);
    f(24'hc00000, st);
    f(24'hc00000, 24'h000000);
    f(24'h451234, 24'h000000);
    f(24'h530060, st);
    @(posedge clk_sys);
    #1;
    i_host.xfer(24'hc00000, w1);
    @(posedge clk_sys);
    #1;
    i_host.xfer(24'hc00000, w2);
    check("alt", {23'h0, (w1 === st && w2 === 24'h00c000) || (w1 === 24'h005300 && w2 === st)}, 24'h1);
    give_verdict();
  end

  // The run needs about 70 us, so this only cuts a hang.
  initial
  begin
    #300000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
